// ==== rtl/popd_core.sv ====
// executor for port output, or, and the two power-off instructions
`timescale 1ns/1ps
`default_nettype none
module popd_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [9:0] instr,
  input wire logic [3:0] mem_at_data_pointer,
  input wire logic carry_flag_in,
  output logic [3:0] acc,
  output logic [3:0] output_port_two,
  output logic [9:0] pc,
  output popd_pkg::popd_mode_t mode,
  output logic carry_flag,
  output logic skip_next
);
  popd_pkg::popd_dec_t dec;
  popd_pkg::popd_state_t st_reg;
  popd_pkg::popd_state_t st_next;

  popd_decode u_decode (
    .instr(instr),
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: instructions only run while the core is in run mode
  always_comb
  begin
    st_next = st_reg;
    if (instr_valid && st_reg.mode == popd_pkg::POPD_RUN)
    begin
      st_next.pc = st_reg.pc + popd_pkg::PC_STEP;
      // the enable arms only the very next instruction
      st_next.armed = dec.enable;
      if (dec.port_out)
      begin
        st_next.port2 = st_reg.acc;
      end
      else if (dec.or_mem)
      begin
        st_next.acc = st_reg.acc | mem_at_data_pointer;
      end
      else if (dec.sleep && st_reg.armed)
      begin
        st_next.mode = popd_pkg::POPD_CLOCK_SLEEP;
      end
      else if (dec.backup && st_reg.armed)
      begin
        st_next.mode = popd_pkg::POPD_RAM_BACKUP;
      end
      // unarmed power-off falls through as a plain no-op
    end
  end

  // register the whole state; only the reset in this block leaves a power mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg.acc <= popd_pkg::ACC_RESET;
      st_reg.port2 <= popd_pkg::PORT2_RESET;
      st_reg.pc <= popd_pkg::PC_RESET;
      st_reg.armed <= popd_pkg::ARMED_RESET;
      st_reg.mode <= popd_pkg::POPD_RUN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state; carry passes through untouched, skip_next tied low
  assign acc = st_reg.acc;
  assign output_port_two = st_reg.port2;
  assign pc = st_reg.pc;
  assign mode = st_reg.mode;
  assign carry_flag = carry_flag_in;
  assign skip_next = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_armed_then(logic op);
    instr_valid && dec.enable && mode == popd_pkg::POPD_RUN
      ##1 instr_valid && op;
  endsequence
  // one instruction taken while the core is still running
  sequence s_exec(logic op);
    instr_valid && op && mode == popd_pkg::POPD_RUN;
  endsequence
  // enable, one idle edge, then the power-off: an idle edge keeps the arm
  sequence s_armed_gap(logic op);
    s_exec(dec.enable) ##1 !instr_valid ##1 instr_valid && op;
  endsequence
  // enable spent on another instruction before the power-off arrives
  sequence s_spent_arm(logic op);
    s_exec(dec.enable) ##1 !instr_valid ##1 s_exec(!dec.enable)
      ##1 !instr_valid ##1 s_exec(op);
  endsequence

  a_port_copy: assert property (@(posedge clk) disable iff (rst)
    instr_valid && dec.port_out && mode == popd_pkg::POPD_RUN
      |=> output_port_two == $past(acc))
    else $error("port two does not hold accumulator");
  a_or_result: assert property (@(posedge clk) disable iff (rst)
    instr_valid && dec.or_mem && mode == popd_pkg::POPD_RUN
      |=> acc == ($past(acc) | $past(mem_at_data_pointer)))
    else $error("or result wrong");
  a_sleep_enter: assert property (@(posedge clk) disable iff (rst)
    s_armed_then(dec.sleep) |=> mode == popd_pkg::POPD_CLOCK_SLEEP)
    else $error("armed sleep not entered");
  a_sleep_noop: assert property (@(posedge clk) disable iff (rst)
    instr_valid && dec.sleep && !st_reg.armed && mode == popd_pkg::POPD_RUN
      |=> mode == popd_pkg::POPD_RUN && $stable(acc) && $stable(output_port_two))
    else $error("unarmed sleep changed state");
  a_backup_enter: assert property (@(posedge clk) disable iff (rst)
    s_armed_then(dec.backup) |=> mode == popd_pkg::POPD_RAM_BACKUP)
    else $error("armed backup not entered");
  a_backup_noop: assert property (@(posedge clk) disable iff (rst)
    instr_valid && dec.backup && !st_reg.armed && mode == popd_pkg::POPD_RUN
      |=> mode == popd_pkg::POPD_RUN && $stable(acc))
    else $error("unarmed backup changed mode");
  a_noop_step: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr == popd_pkg::OP_NO_OPERATION && mode == popd_pkg::POPD_RUN
      |=> pc == $past(pc) + popd_pkg::PC_STEP && $stable(acc)
        && $stable(output_port_two) && $stable(mode))
    else $error("no-op changed more than pc");
  a_carry_kept: assert property (@(posedge clk) disable iff (rst)
    carry_flag == carry_flag_in && !skip_next)
    else $error("carry or skip disturbed");

  // port two moves only on its own instruction
  a_port_only_out: assert property (@(posedge clk) disable iff (rst)
    !(instr_valid && dec.port_out && mode == popd_pkg::POPD_RUN)
      |=> $stable(output_port_two))
    else $error("port two changed without port instruction");

  // port output leaves accumulator and mode alone
  a_port_keeps_acc: assert property (@(posedge clk) disable iff (rst)
    s_exec(dec.port_out) |=> $stable(acc) && mode == popd_pkg::POPD_RUN)
    else $error("port output disturbed accumulator or mode");

  // or leaves the port and the mode alone
  a_or_keeps_port: assert property (@(posedge clk) disable iff (rst)
    s_exec(dec.or_mem) |=> $stable(output_port_two) && mode == popd_pkg::POPD_RUN)
    else $error("or disturbed port two or mode");

  // only the or writes the accumulator
  a_acc_only_or: assert property (@(posedge clk) disable iff (rst)
    !(instr_valid && dec.or_mem && mode == popd_pkg::POPD_RUN) |=> $stable(acc))
    else $error("accumulator changed without or");

  // an executed enable arms the next instruction
  a_arm_set: assert property (@(posedge clk) disable iff (rst)
    s_exec(dec.enable) |=> st_reg.armed)
    else $error("enable did not arm");

  // any other executed instruction drops the arm
  a_arm_cleared: assert property (@(posedge clk) disable iff (rst)
    s_exec(!dec.enable) |=> !st_reg.armed)
    else $error("arm outlived the next instruction");

  // an unarmed core cannot leave run mode
  a_unarmed_stays: assert property (@(posedge clk) disable iff (rst)
    mode == popd_pkg::POPD_RUN && !st_reg.armed |=> mode == popd_pkg::POPD_RUN)
    else $error("mode left run without arm");

  // enable spent on a no-op does not carry over to a later sleep
  a_spent_sleep: assert property (@(posedge clk) disable iff (rst)
    s_spent_arm(dec.sleep) |=> mode == popd_pkg::POPD_RUN)
    else $error("spent enable still armed sleep");

  // idle edge between enable and backup keeps the arm
  a_backup_gap: assert property (@(posedge clk) disable iff (rst)
    s_armed_gap(dec.backup) |=> mode == popd_pkg::POPD_RAM_BACKUP)
    else $error("backup after idle edge not entered");

  // sleep is only reached through its own instruction
  a_sleep_only_op: assert property (@(posedge clk) disable iff (rst)
    mode == popd_pkg::POPD_RUN && !(instr_valid && dec.sleep)
      |=> mode != popd_pkg::POPD_CLOCK_SLEEP)
    else $error("clock sleep entered without its instruction");

  // backup is only reached through its own instruction
  a_backup_only_op: assert property (@(posedge clk) disable iff (rst)
    mode == popd_pkg::POPD_RUN && !(instr_valid && dec.backup)
      |=> mode != popd_pkg::POPD_RAM_BACKUP)
    else $error("ram backup entered without its instruction");

  // clock sleep freezes the core until reset; wake-up lives elsewhere
  a_sleep_held: assert property (@(posedge clk) disable iff (rst)
    mode == popd_pkg::POPD_CLOCK_SLEEP |=> mode == popd_pkg::POPD_CLOCK_SLEEP
      && $stable(pc) && $stable(acc) && $stable(output_port_two))
    else $error("core moved during clock sleep");

  // ram backup freezes the core until reset
  a_backup_held: assert property (@(posedge clk) disable iff (rst)
    mode == popd_pkg::POPD_RAM_BACKUP |=> mode == popd_pkg::POPD_RAM_BACKUP
      && $stable(pc) && $stable(acc) && $stable(output_port_two))
    else $error("core moved during ram backup");

  // every executed instruction steps pc by exactly one
  a_pc_step: assert property (@(posedge clk) disable iff (rst)
    s_exec(1'b1) |=> pc == $past(pc) + popd_pkg::PC_STEP)
    else $error("pc step wrong");

  // an idle edge changes nothing, the arm included
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    !instr_valid |=> $stable(pc) && $stable(acc) && $stable(output_port_two)
      && $stable(mode) && $stable(st_reg.armed))
    else $error("idle edge changed state");

  // enable, no-op and unknown codes touch neither accumulator, port nor mode
  a_other_ops_idle: assert property (@(posedge clk) disable iff (rst)
    s_exec(!(dec.port_out || dec.or_mem || dec.sleep || dec.backup))
      |=> $stable(acc) && $stable(output_port_two) && mode == popd_pkg::POPD_RUN)
    else $error("non-data instruction changed state");
endmodule
`default_nettype wire

// ==== shared/popd_pkg.sv ====
// package for the port/or/power-off instruction executor
package popd_pkg;
  // 10-bit instruction codes
  localparam logic [9:0] OP_PORT2_OUT = 10'h222;
  localparam logic [9:0] OP_OR = 10'h019;
  localparam logic [9:0] OP_CLOCK_SLEEP = 10'h002;
  localparam logic [9:0] OP_RAM_BACKUP = 10'h008;
  localparam logic [9:0] OP_POWER_OFF_ENABLE = 10'h22b;
  localparam logic [9:0] OP_NO_OPERATION = 10'h000;
  // reset values and program counter step
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic [3:0] PORT2_RESET = 4'h0;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic ARMED_RESET = 1'b0;

  // operating modes, gray coded
  typedef enum logic [1:0] {
    POPD_RUN = 2'b00,
    POPD_CLOCK_SLEEP = 2'b01,
    POPD_RAM_BACKUP = 2'b11
  } popd_mode_t;

  // decoded instruction flags
  typedef struct packed {
    logic port_out;
    logic or_mem;
    logic sleep;
    logic backup;
    logic enable;
  } popd_dec_t;

  // whole state of the executor
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] port2;
    logic [9:0] pc;
    logic armed;
    popd_mode_t mode;
  } popd_state_t;
endpackage

// ==== rtl/popd_decode.sv ====
// instruction decoder for the executor
`timescale 1ns/1ps
`default_nettype none
module popd_decode (
  input wire logic [9:0] instr,
  output popd_pkg::popd_dec_t dec
);
  // one flag per recognised opcode, all clear for anything else
  always_comb
  begin
    dec.port_out = (instr == popd_pkg::OP_PORT2_OUT);
    dec.or_mem = (instr == popd_pkg::OP_OR);
    dec.sleep = (instr == popd_pkg::OP_CLOCK_SLEEP);
    dec.backup = (instr == popd_pkg::OP_RAM_BACKUP);
    dec.enable = (instr == popd_pkg::OP_POWER_OFF_ENABLE);
  end
endmodule
`default_nettype wire

// ==== tb/popd_core_bench.sv ====
// self-checking bench for the port/or/power-off executor
`timescale 1ns/1ps
`default_nettype none
module popd_core_bench;
  logic clk, rst, instr_valid, carry_flag_in, carry_flag, skip_next;
  logic [9:0] instr, pc;
  logic [3:0] mem_at_data_pointer, acc, output_port_two;
  popd_pkg::popd_mode_t mode;
  int err_total, n_compared;
  popd_core i_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .mem_at_data_pointer(mem_at_data_pointer), .carry_flag_in(carry_flag_in), .acc(acc),
    .output_port_two(output_port_two), .pc(pc), .mode(mode), .carry_flag(carry_flag),
    .skip_next(skip_next));
  ////////////////////////////////////////
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  // one executed instruction; valid drops so results are read after the taking edge
  task automatic run(input logic [9:0] op, input logic [3:0] m);
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr = op;
    mem_at_data_pointer = m;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
  endtask
  // two instructions on consecutive edges, no idle edge between them
  task automatic run_pair(input logic [9:0] op_a, input logic [9:0] op_b);
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr = op_a;
    mem_at_data_pointer = 4'h0;
    @(posedge clk);
    #1;
    instr = op_b;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
  endtask
  task automatic do_reset;
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // or twice then port out; carry passes and no skip
  task automatic t_or_port;
    run(popd_pkg::OP_OR, 4'h5);
    chk(acc, 4'h5);
    run(popd_pkg::OP_OR, 4'ha);
    chk(acc, 4'hf);
    run(popd_pkg::OP_PORT2_OUT, 4'h0);
    chk(output_port_two, 4'hf);
    chk(pc, 10'h003);
    chk({carry_flag, skip_next}, 2'b10);
  endtask
  // power-off without enable, and enable spent on a no-op first
  task automatic t_unarmed;
    run(popd_pkg::OP_CLOCK_SLEEP, 4'h3);
    chk(mode, popd_pkg::POPD_RUN);
    run(popd_pkg::OP_RAM_BACKUP, 4'h3);
    chk(mode, popd_pkg::POPD_RUN);
    run(popd_pkg::OP_POWER_OFF_ENABLE, 4'h3);
    run(popd_pkg::OP_NO_OPERATION, 4'h3);
    chk({acc, output_port_two}, 8'hff);
    carry_flag_in = 1'b0;
    run(popd_pkg::OP_CLOCK_SLEEP, 4'h3);
    chk(mode, popd_pkg::POPD_RUN);
    chk(pc, 10'h008);
    chk({carry_flag, skip_next}, 2'b00);
  endtask
  // armed sleep back to back, then a refused instruction leaves pc alone
  task automatic t_sleep;
    run_pair(popd_pkg::OP_POWER_OFF_ENABLE, popd_pkg::OP_CLOCK_SLEEP);
    chk(mode, popd_pkg::POPD_CLOCK_SLEEP);
    run(popd_pkg::OP_OR, 4'h0);
    chk(pc, 10'h00a);
  endtask
  // armed backup across an idle edge, then back to back after a fresh reset
  task automatic t_backup;
    run(popd_pkg::OP_POWER_OFF_ENABLE, 4'h0);
    run(popd_pkg::OP_RAM_BACKUP, 4'h0);
    chk(mode, popd_pkg::POPD_RAM_BACKUP);
    do_reset;
    run_pair(popd_pkg::OP_POWER_OFF_ENABLE, popd_pkg::OP_RAM_BACKUP);
    chk(mode, popd_pkg::POPD_RAM_BACKUP);
    run(popd_pkg::OP_OR, 4'hf);
    chk(acc, 4'h0);
  endtask
  ////////////////////////////////////////
  // main sequence; power modes leave only through reset
  initial
  begin
    {rst, instr_valid, carry_flag_in} = 3'b101;
    instr = 10'h000;
    mem_at_data_pointer = 4'h0;
    do_reset;
    t_or_port;
    t_unarmed;
    t_sleep;
    do_reset;
    t_backup;
    stop_test;
  end
  // watchdog well beyond the fifty or so cycles the run needs
  initial
  begin
    #20000;
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
